//--- verilog/timer_regs_defines.vh
// Register map, field positions, reset values and codes of the timer.
// Assumes a 32-bit APB slave port with byte addresses on paddr[7:0].
`ifndef TIMER_REGS_DEFINES_VH
`define TIMER_REGS_DEFINES_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define TMR_OFS_CTRL 8'h00
`define TMR_OFS_COUNT 8'h04
`define TMR_OFS_MODULO 8'h08
`define TMR_OFS_CH_BASE 8'h10
`define TMR_CH_STRIDE_LOG2 3
`define TMR_OFS_CH_VALUE 8'h04

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define TMR_PS_LSB 0
`define TMR_PS_MSB 2
`define TMR_CSS_LSB 3
`define TMR_CSS_MSB 4
`define TMR_CENTER_ALIGN_SELECT_BIT 5
`define TMR_TOIE_BIT 6
`define TMR_TOF_BIT 7

// ----------------------------------------------------------------------
// Channel status/control fields
// ----------------------------------------------------------------------
`define TMR_ELS_LSB 0
`define TMR_ELS_MSB 1
`define TMR_MS_LSB 2
`define TMR_MS_MSB 3
`define TMR_CHIE_BIT 4
`define TMR_CHF_BIT 5

// ----------------------------------------------------------------------
// Codes and reset values
// ----------------------------------------------------------------------
`define TMR_CSS_OFF 2'b00
`define TMR_CSS_BUS 2'b01
`define TMR_CSS_FIXED 2'b10
`define TMR_CSS_EXT 2'b11
`define TMR_ELS_NONE 2'b00
`define TMR_MS_CAPTURE 2'b00
`define TMR_MS_COMPARE 2'b01
`define TMR_CNT_ZERO 16'h0000
`define TMR_CNT_FULL 16'hFFFF
`define TMR_RST_MODULO 16'h0000
`define TMR_RST_CHV 16'h0000
`define TMR_NUM_CH 4

`endif

//--- verilog/sync_edge.v
// Two-flop synchroniser with edge detection behind the second stage.
// Assumes d may change at any time relative to clk.
`timescale 1ns/1ps

module sync_edge (
  input wire clk, // Bus clock
  input wire rst_n, // Asynchronous reset, active low
  input wire d, // Raw level to synchronise
  output wire q, // Synchronised level
  output wire rise, // One-cycle pulse on a rising edge
  output wire fall // One-cycle pulse on a falling edge
);

  // --------------------------------------------------------------------
  // Synchroniser stages
  // --------------------------------------------------------------------
  reg meta_r; // First stage, read only by the second
  reg sync_r; // Second stage, safe to use
  reg last_r; // Delayed copy for edge detection

  // Shift chain; edges come from stages two and three only
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
    end else begin
      meta_r <= d;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  assign q = sync_r;
  assign rise = sync_r & ~last_r;
  assign fall = ~sync_r & last_r;

endmodule // sync_edge

//--- verilog/timer_capture_compare_pwm.v
// 16-bit timer with four capture / compare / PWM channels and an APB
// register port. Assumes pclk is the bus clock and all pins arrive
// through the synchronisers in this block.
//
// Chosen here: the APB register port and the address map.
`timescale 1ns/1ps
`include "timer_regs_defines.vh"

module timer_capture_compare_pwm (
  input wire pclk, // Bus clock, 50 MHz
  input wire presetn, // Asynchronous reset, active low
  input wire psel, // APB select
  input wire penable, // APB access phase
  input wire pwrite, // APB direction, high for write
  input wire [7:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  output wire [31:0] prdata, // APB read data
  output wire pready, // APB ready
  output wire pslverr, // APB error on unmapped address
  input wire fixed_clk_in, // Fixed system clock source
  input wire ext_clk_in, // External clock pin
  input wire background_debug_mode, // High while in debug
  input wire stop_mode, // High while system clocks halt
  input wire [3:0] timer_channel_pin_i, // Channel pin level in
  output wire [3:0] timer_channel_pin_o, // Channel pin drive value
  output wire [3:0] timer_channel_pin_oe, // Channel pin drive enable
  output wire [3:0] timer_channel_pin_own, // Timer owns the pin
  output wire [3:0] channel_irq, // Per-channel interrupt request
  output wire overflow_irq // Terminal count interrupt request
);

  // --------------------------------------------------------------------
  // Helper functions
  // --------------------------------------------------------------------
  // Low-bit mask for a power-of-two tap: 0 -> 0, 7 -> 7'h7F
  function [6:0] presc_mask;
    input [2:0] ps;
    begin
      presc_mask = ~(7'h7F << ps);
    end
  endfunction

  // True when the edge/level select is anything but 0:0
  function sel_on;
    input [1:0] els;
    begin
      sel_on = (els != `TMR_ELS_NONE);
    end
  endfunction

  // --------------------------------------------------------------------
  // Registers and state
  // --------------------------------------------------------------------
  reg [2:0] ps_r; // Prescale tap
  reg [1:0] clock_source_select_r; // Clock source
  reg center_align_select_r; // Module-wide center PWM
  reg toie_r; // Overflow interrupt enable
  reg tof_r; // Overflow flag, sticky
  reg [15:0] counter_modulo_value_r; // Modulo
  reg [15:0] timer_count_value_r; // Main counter
  reg up_r; // Count direction in center mode
  reg [6:0] pre_r; // Prescaler chain
  reg [1:0] edge_level_select_r [0:3]; // Per-channel edge/level
  reg [1:0] channel_mode_select_r [0:3]; // Per-channel mode
  reg [3:0] chie_r; // Channel interrupt enables
  reg [3:0] chf_r; // Channel flags, sticky
  reg [15:0] chv_r [0:3]; // Channel values
  reg [3:0] out_r; // Channel output levels
  reg [31:0] prdata_r; // Read data register

  // --------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------
  wire fixed_rise; // Fixed clock rising edge
  wire ext_rise; // External clock rising edge
  wire [3:0] pin_rise; // Channel pin rising edges
  wire [3:0] pin_fall; // Channel pin falling edges

  // Fixed clock is only seen through bus-clock flops
  sync_edge u_sync_fixed (
    .clk(pclk),
    .rst_n(presetn),
    .d(fixed_clk_in),
    .q(),
    .rise(fixed_rise),
    .fall()
  );

  // External clock must stay below a quarter of the bus rate
  sync_edge u_sync_ext (
    .clk(pclk),
    .rst_n(presetn),
    .d(ext_clk_in),
    .q(),
    .rise(ext_rise),
    .fall()
  );

  genvar g;
  generate
    for (g = 0; g < `TMR_NUM_CH; g = g + 1) begin : g_pin_sync
      // Capture edges need at least two bus clocks of pulse width
      sync_edge u_sync_pin (
        .clk(pclk),
        .rst_n(presetn),
        .d(timer_channel_pin_i[g]),
        .q(),
        .rise(pin_rise[g]),
        .fall(pin_fall[g])
      );
    end
  endgenerate

  // --------------------------------------------------------------------
  // APB decode
  // --------------------------------------------------------------------
  wire setup_ph = psel & ~penable; // Setup cycle
  wire access_ph = psel & penable; // Access cycle, always ready
  wire wr_en = access_ph & pwrite; // Write strobe
  wire is_ch = (paddr[7:4] == `TMR_OFS_CH_BASE >> 4) |
               (paddr[7:4] == (`TMR_OFS_CH_BASE >> 4) + 4'h1);
  // Channel n sits at base plus 8n; index from the offset, not raw bits
  wire [7:0] ch_ofs = paddr - `TMR_OFS_CH_BASE; // Offset into channel area
  wire [1:0] ch_idx = ch_ofs[`TMR_CH_STRIDE_LOG2 + 1:`TMR_CH_STRIDE_LOG2];
  wire ch_val_sel = paddr[2]; // Value word versus control word
  wire hit_ctrl = (paddr == `TMR_OFS_CTRL);
  wire hit_cnt = (paddr == `TMR_OFS_COUNT);
  wire hit_mod = (paddr == `TMR_OFS_MODULO);
  wire hit_ch = is_ch & (paddr[1:0] == 2'b00);
  wire mapped = hit_ctrl | hit_cnt | hit_mod | hit_ch;

  assign pready = 1'b1;
  assign pslverr = access_ph & ~mapped;
  assign prdata = prdata_r;

  // Read data is staged in the setup cycle; reads have no side effects
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup_ph & ~pwrite) begin
      prdata_r <= 32'h0000_0000;
      if (hit_ctrl) begin
        prdata_r[`TMR_PS_MSB:`TMR_PS_LSB] <= ps_r;
        prdata_r[`TMR_CSS_MSB:`TMR_CSS_LSB] <= clock_source_select_r;
        prdata_r[`TMR_CENTER_ALIGN_SELECT_BIT] <= center_align_select_r;
        prdata_r[`TMR_TOIE_BIT] <= toie_r;
        prdata_r[`TMR_TOF_BIT] <= tof_r;
      end else if (hit_cnt) begin
        prdata_r[15:0] <= timer_count_value_r;
      end else if (hit_mod) begin
        prdata_r[15:0] <= counter_modulo_value_r;
      end else if (hit_ch & ch_val_sel) begin
        prdata_r[15:0] <= chv_r[ch_idx];
      end else if (hit_ch) begin
        prdata_r[`TMR_ELS_MSB:`TMR_ELS_LSB] <= edge_level_select_r[ch_idx];
        prdata_r[`TMR_MS_MSB:`TMR_MS_LSB] <= channel_mode_select_r[ch_idx];
        prdata_r[`TMR_CHIE_BIT] <= chie_r[ch_idx];
        prdata_r[`TMR_CHF_BIT] <= chf_r[ch_idx];
      end
    end
  end

  // --------------------------------------------------------------------
  // Clock source, prescaler and counter tick
  // --------------------------------------------------------------------
  reg src_tick; // Selected source edge
  // Source choice; off stops the prescaler and counter
  always @* begin
    case (clock_source_select_r)
      `TMR_CSS_BUS: src_tick = 1'b1;
      `TMR_CSS_FIXED: src_tick = fixed_rise;
      `TMR_CSS_EXT: src_tick = ext_rise;
      default: src_tick = 1'b0;
    endcase
  end

  // Debug and stop both freeze the timer; wait mode has no effect
  wire run = ~background_debug_mode & ~stop_mode;
  wire pre_step = src_tick & run;
  wire [6:0] pmask = presc_mask(ps_r);
  wire tick = pre_step & ((pre_r & pmask) == pmask);
  wire cnt_wr = wr_en & hit_cnt;

  // Prescaler chain restarts with the counter
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_r <= 7'h00;
    end else if (cnt_wr) begin
      pre_r <= 7'h00;
    end else if (pre_step) begin
      pre_r <= pre_r + 7'h01;
    end
  end

  // --------------------------------------------------------------------
  // Main counter
  // --------------------------------------------------------------------
  wire free_run = (counter_modulo_value_r == `TMR_CNT_ZERO) |
                  (counter_modulo_value_r == `TMR_CNT_FULL);
  wire [15:0] top = free_run ? `TMR_CNT_FULL : counter_modulo_value_r;
  // Edge mode wraps after top; center mode turns at top and at zero
  wire wrap_edge = tick & ~center_align_select_r &
                   (timer_count_value_r == top);
  wire turn_zero = tick & center_align_select_r & ~up_r &
                   (timer_count_value_r == `TMR_CNT_ZERO);
  wire period_end = wrap_edge | turn_zero;

  // Counter update; holds between prescaler pulses
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_count_value_r <= `TMR_CNT_ZERO;
      up_r <= 1'b1;
    end else if (cnt_wr) begin
      timer_count_value_r <= `TMR_CNT_ZERO;
      up_r <= 1'b1;
    end else if (tick) begin
      if (!center_align_select_r) begin
        if (wrap_edge) begin
          timer_count_value_r <= `TMR_CNT_ZERO;
        end else begin
          timer_count_value_r <= timer_count_value_r + 16'h0001;
        end
      end else if (up_r) begin
        if (timer_count_value_r >= top) begin
          up_r <= 1'b0;
          timer_count_value_r <= timer_count_value_r - 16'h0001;
        end else begin
          timer_count_value_r <= timer_count_value_r + 16'h0001;
        end
      end else begin
        if (turn_zero) begin
          up_r <= 1'b1;
          timer_count_value_r <= 16'h0001;
        end else begin
          timer_count_value_r <= timer_count_value_r - 16'h0001;
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // Module control, modulo and overflow flag
  // --------------------------------------------------------------------
  wire ctrl_wr = wr_en & hit_ctrl;

  // Overflow flag: set wins over a write-one clear in the same cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ps_r <= 3'b000;
      clock_source_select_r <= `TMR_CSS_OFF;
      center_align_select_r <= 1'b0;
      toie_r <= 1'b0;
      tof_r <= 1'b0;
      counter_modulo_value_r <= `TMR_RST_MODULO;
    end else begin
      if (ctrl_wr) begin
        ps_r <= pwdata[`TMR_PS_MSB:`TMR_PS_LSB];
        clock_source_select_r <= pwdata[`TMR_CSS_MSB:`TMR_CSS_LSB];
        center_align_select_r <= pwdata[`TMR_CENTER_ALIGN_SELECT_BIT];
        toie_r <= pwdata[`TMR_TOIE_BIT];
      end
      if (wr_en & hit_mod) begin
        counter_modulo_value_r <= pwdata[15:0];
      end
      if (period_end) begin
        tof_r <= 1'b1;
      end else if (ctrl_wr & pwdata[`TMR_TOF_BIT]) begin
        tof_r <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // Channel mode decode
  // --------------------------------------------------------------------
  reg [3:0] m_cap; // Input capture active
  reg [3:0] m_cmp; // Output compare (software timer when select 0:0)
  reg [3:0] m_edge_aligned_pwm_mode; // Edge-aligned PWM active
  reg [3:0] m_center_aligned_pwm_mode; // Center-aligned PWM active
  reg [3:0] own; // Timer controls the pin
  integer i; // Loop index of the clocked channel process
  integer j; // Loop index of the mode decode
  integer k; // Loop index of the event detection

  // Center bit overrides every per-channel mode
  always @* begin
    for (j = 0; j < `TMR_NUM_CH; j = j + 1) begin
      m_cap[j] = ~center_align_select_r &
                 (channel_mode_select_r[j] == `TMR_MS_CAPTURE) &
                 sel_on(edge_level_select_r[j]);
      m_cmp[j] = ~center_align_select_r &
                 (channel_mode_select_r[j] == `TMR_MS_COMPARE);
      m_edge_aligned_pwm_mode[j] = ~center_align_select_r & channel_mode_select_r[j][1] &
                  sel_on(edge_level_select_r[j]);
      m_center_aligned_pwm_mode[j] = center_align_select_r &
                  sel_on(edge_level_select_r[j]);
      own[j] = sel_on(edge_level_select_r[j]) &
               (clock_source_select_r != `TMR_CSS_OFF);
    end
  end

  assign timer_channel_pin_own = own;
  assign timer_channel_pin_oe = own & ~m_cap;
  assign timer_channel_pin_o = out_r;
  assign channel_irq = chf_r & chie_r;
  assign overflow_irq = tof_r & toie_r;

  // --------------------------------------------------------------------
  // Channel registers, capture, compare and PWM outputs
  // --------------------------------------------------------------------
  reg [3:0] cap_ev; // Selected capture edge seen
  reg [3:0] match; // Counter equals channel value on a tick
  reg [3:0] ch_ev; // Any event that sets the channel flag

  // Event detection per channel
  always @* begin
    for (k = 0; k < `TMR_NUM_CH; k = k + 1) begin
      case (edge_level_select_r[k])
        2'b01: cap_ev[k] = pin_rise[k];
        2'b10: cap_ev[k] = pin_fall[k];
        2'b11: cap_ev[k] = pin_rise[k] | pin_fall[k];
        default: cap_ev[k] = 1'b0;
      endcase
      // Stop halts every clock, so no capture may land meanwhile
      cap_ev[k] = cap_ev[k] & m_cap[k] & ~stop_mode;
      match[k] = tick & (timer_count_value_r == chv_r[k]);
      ch_ev[k] = cap_ev[k] |
                 (match[k] & (m_cmp[k] | m_edge_aligned_pwm_mode[k] | m_center_aligned_pwm_mode[k]));
    end
  end

  // Channel state; flag set beats a write-one clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < `TMR_NUM_CH; i = i + 1) begin
        edge_level_select_r[i] <= `TMR_ELS_NONE;
        channel_mode_select_r[i] <= `TMR_MS_CAPTURE;
        chv_r[i] <= `TMR_RST_CHV;
      end
      chie_r <= 4'h0;
      chf_r <= 4'h0;
      out_r <= 4'h0;
    end else begin
      for (i = 0; i < `TMR_NUM_CH; i = i + 1) begin
        // Software access to this channel's words
        if (wr_en & hit_ch & (ch_idx == i[1:0]) & ~ch_val_sel) begin
          edge_level_select_r[i] <= pwdata[`TMR_ELS_MSB:`TMR_ELS_LSB];
          channel_mode_select_r[i] <= pwdata[`TMR_MS_MSB:`TMR_MS_LSB];
          chie_r[i] <= pwdata[`TMR_CHIE_BIT];
        end
        // Capture takes priority over a software value write
        if (cap_ev[i]) begin
          chv_r[i] <= timer_count_value_r;
        end else if (wr_en & hit_ch & (ch_idx == i[1:0]) & ch_val_sel) begin
          chv_r[i] <= pwdata[15:0];
        end
        if (ch_ev[i]) begin
          chf_r[i] <= 1'b1;
        end else if (wr_en & hit_ch & (ch_idx == i[1:0]) & ~ch_val_sel &
                     pwdata[`TMR_CHF_BIT]) begin
          chf_r[i] <= 1'b0;
        end
        // Output level; toggle keeps the old level until first match
        if (m_cmp[i] & match[i]) begin
          case (edge_level_select_r[i])
            2'b01: out_r[i] <= ~out_r[i];
            2'b10: out_r[i] <= 1'b0;
            2'b11: out_r[i] <= 1'b1;
            default: out_r[i] <= out_r[i];
          endcase
        end else if (m_edge_aligned_pwm_mode[i] & match[i]) begin
          out_r[i] <= edge_level_select_r[i][0];
        end else if (m_edge_aligned_pwm_mode[i] & wrap_edge) begin
          out_r[i] <= ~edge_level_select_r[i][0];
        end else if (m_center_aligned_pwm_mode[i] & match[i]) begin
          // Down match goes active, up match goes inactive
          out_r[i] <= up_r ? edge_level_select_r[i][0]
                           : ~edge_level_select_r[i][0];
        end
      end
    end
  end

endmodule // timer_capture_compare_pwm

//--- tb/timer_asserts.sv
// Port-level checker for the timer, bound into its top module.
// Assumes one clock, pclk, and presetn as async active-low reset.
`timescale 1ns/1ps
module timer_asserts (
  input wire pclk, // Bus clock
  input wire presetn, // Reset, active low
  input wire psel, // APB select
  input wire penable, // APB access
  input wire pwrite, // APB write
  input wire [31:0] prdata, // Read data
  input wire background_debug_mode, // Debug level
  input wire stop_mode, // Stop level
  input wire [3:0] timer_channel_pin_o, // Pin value
  input wire [3:0] timer_channel_pin_oe, // Pin enable
  input wire [3:0] timer_channel_pin_own, // Pin owned
  input wire [3:0] channel_irq, // Channel requests
  input wire overflow_irq // Overflow request
);
  // A register write is the only cause of a software-driven change
  wire wr = psel && penable && pwrite;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_oe_own;
    !(|(timer_channel_pin_oe & ~timer_channel_pin_own)); endproperty
  a_oe_own: assert property (p_oe_own) else $error("unowned drive");
  property p_rst;
    $rose(presetn) |-> timer_channel_pin_own == 4'h0; endproperty
  a_rst: assert property (p_rst) else $error("pin owned at reset");
  // Three cycles of margin cover the registered pin and overflow outputs
  property p_dbg;
    (background_debug_mode && !psel) [*3] |->
      $stable(timer_channel_pin_o) && $stable(overflow_irq); endproperty
  a_dbg: assert property (p_dbg) else $error("moved in debug");
  property p_stop;
    (stop_mode && !psel) [*3] |-> $stable(timer_channel_pin_o) &&
      $stable(channel_irq) && $stable(overflow_irq); endproperty
  a_stop: assert property (p_stop) else $error("moved in stop");
  property p_prd;
    !(psel && !penable && !pwrite) |=> $stable(prdata); endproperty
  a_prd: assert property (p_prd) else $error("read data moved");
  property p_ovf;
    $fell(overflow_irq) |-> $past(wr); endproperty
  a_ovf: assert property (p_ovf) else $error("overflow dropped");
  property p_chirq;
    |($past(channel_irq) & ~channel_irq) |-> $past(wr); endproperty
  a_chirq: assert property (p_chirq) else $error("channel dropped");
  property p_own;
    $changed(timer_channel_pin_own) |-> $past(wr); endproperty
  a_own: assert property (p_own) else $error("ownership moved");
endmodule // timer_asserts

bind timer_capture_compare_pwm timer_asserts u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata),
  .background_debug_mode(background_debug_mode), .stop_mode(stop_mode),
  .timer_channel_pin_o(timer_channel_pin_o),
  .timer_channel_pin_oe(timer_channel_pin_oe),
  .timer_channel_pin_own(timer_channel_pin_own),
  .channel_irq(channel_irq), .overflow_irq(overflow_irq)
);

//--- tb/pin_model.sv
// Far side of the timer: channel pin levels and slow clock sources.
// Assumes pclk runs it; both sources run at one eighth of pclk.
`timescale 1ns/1ps
module pin_model (
  input wire pclk, // Bus clock
  input wire ext_en, // Lets the external clock run
  input wire [3:0] drv, // Level the outside world drives
  input wire [3:0] oe, // Timer drive enable
  input wire [3:0] o, // Timer drive value
  output wire [3:0] pin, // Resolved pin levels
  output wire fclk, // Fixed clock, free running
  output wire eclk // External clock, still when gated
);
  logic [2:0] div = 3'h0; // Fixed clock phase
  logic [2:0] ediv = 3'h0; // External phase, frozen while gated
  // Timer value wins where it drives; outside level elsewhere
  assign pin = (oe & o) | (~oe & drv);
  // Eighth rate keeps well inside the quarter-rate input limit
  always @(posedge pclk) begin
    div <= div + 3'h1;
    if (ext_en) begin
      ediv <= ediv + 3'h1;
    end
  end
  assign fclk = div[2];
  assign eclk = ediv[2];
endmodule // pin_model

//--- tb/tb_timer_capture_compare_pwm.sv
// Self-checking bench for the timer: APB driver, stimulus, checks.
// Assumes the pin model sits on the channel pins and clock inputs.
`timescale 1ns/1ps
module tb_timer_capture_compare_pwm;
  logic pclk = 1'b0; // Bus clock
  logic presetn = 1'b0; // Reset, active low
  logic psel = 1'b0; // APB select
  logic penable = 1'b0; // APB access
  logic pwrite = 1'b0; // APB write
  logic [7:0] paddr = 8'h00; // APB address
  logic [31:0] pwdata = 32'h0000_0000; // APB data
  logic dbg = 1'b0; // Debug level
  logic stp = 1'b0; // Stop level
  logic ext_en = 1'b0; // External clock gate
  logic [3:0] drv = 4'h0; // Outside pin levels
  logic [31:0] rd; // Last read word
  logic [15:0] c1; // Counter snapshot
  logic p; // Pin snapshot
  logic err; // Error response of the last transfer
  wire [31:0] prdata;
  wire pready, pslverr, fclk, eclk, ovf;
  wire [3:0] pin, po, poe, pown, cirq;
  int error_cnt = 0;
  int check_count = 0;
  int i, n, m, d;
  always #10 pclk = ~pclk;
  timer_capture_compare_pwm u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fixed_clk_in(fclk),
    .ext_clk_in(eclk), .background_debug_mode(dbg), .stop_mode(stp),
    .timer_channel_pin_i(pin), .timer_channel_pin_o(po),
    .timer_channel_pin_oe(poe), .timer_channel_pin_own(pown),
    .channel_irq(cirq), .overflow_irq(ovf));
  pin_model u_pin (.pclk(pclk), .ext_en(ext_en), .drv(drv), .oe(poe),
    .o(po), .pin(pin), .fclk(fclk), .eclk(eclk));
  // Verdict and end of run
  task complete_run;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One APB transfer; holds the request until pready at an edge
  task ap(input logic w, input logic [7:0] a, input logic [31:0] dt);
    int t;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dt;
    @(posedge pclk);
    penable <= 1'b1;
    for (t = 0; t < 16; t++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (t == 16) begin
      error_cnt++;
      complete_run;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Any window of one full period gives an exact high count
  task hi(input int len, input int ch);
    repeat (len) @(posedge pclk);
    n = 0;
    repeat (len) begin
      @(posedge pclk);
      #1 n += po[ch];
    end
  endtask
  initial begin
    void'($urandom(32'h2050));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    ap(0, 8'h0C, 0);
    chk(rd, 0);
    chk(err, 1);
    ap(0, 8'h00, 0);
    chk(rd, 0);
    chk(err, 0);
    chk(pown, 0);
    // Setup edges spaced 8 prescaled ticks apart, every tap
    for (i = 0; i < 8; i++) begin
      ap(1, 8'h00, {27'h0, 2'b01, i[2:0]});
      ap(0, 8'h04, 0);
      c1 = rd[15:0];
      repeat ((8 << i) - 3) @(posedge pclk);
      ap(0, 8'h04, 0);
      chk({16'h0000, rd[15:0] - c1}, 8);
    end
    ap(1, 8'h04, $urandom);
    ap(0, 8'h04, 0);
    chk(rd, 0);
    ap(1, 8'h00, 32'h0000_0008);
    for (i = 0; i < 2; i++) begin
      dbg <= (i == 0);
      stp <= (i == 1);
      ap(0, 8'h04, 0);
      c1 = rd[15:0];
      repeat (20) @(posedge pclk);
      ap(0, 8'h04, 0);
      chk(rd, c1);
    end
    stp <= 1'b0;
    ext_en <= 1'b1;
    for (i = 2; i < 4; i++) begin
      ap(1, 8'h00, {27'h0, i[1:0], 3'h0});
      ap(0, 8'h04, 0);
      c1 = rd[15:0];
      repeat (61) @(posedge pclk);
      ap(0, 8'h04, 0);
      chk({16'h0000, rd[15:0] - c1}, 8);
    end
    ext_en <= 1'b0;
    m = 8 + $urandom % 24;
    ap(1, 8'h00, 0);
    ap(1, 8'h08, m);
    ap(1, 8'h04, 0);
    ap(1, 8'h00, 32'h0000_00C8);
    ap(0, 8'h00, 0);
    chk(rd[7], 0);
    repeat (m) @(posedge pclk);
    ap(0, 8'h00, 0);
    chk(rd[7], 1);
    chk(ovf, 1);
    // Compare actions set, clear, toggle over one period each
    d = $urandom % m;
    ap(1, 8'h14, d);
    for (i = 3; i > 0; i--) begin
      ap(1, 8'h10, {26'h0, 2'b11, 2'b01, i[1:0]});
      #1 p = po[0];
      repeat (m + 1) @(posedge pclk);
      #1 chk(po[0], (i == 1) ? !p : i[0]);
      chk(cirq[0], 1);
    end
    chk(poe[0], 1);
    ap(1, 8'h1C, d);
    for (i = 1; i < 3; i++) begin
      ap(1, 8'h18, {28'h0, 2'b10, i[1:0]});
      hi(m + 1, 1);
      chk(n, (i == 2) ? d + 1 : m - d);
    end
    d = 1 + $urandom % (m - 1);
    ap(1, 8'h24, d);
    ap(1, 8'h20, 32'h0000_0002);
    ap(1, 8'h00, 32'h0000_0028);
    hi(2 * m, 2);
    chk(n, 2 * d);
    // Rising pin edge under every edge select; only selects 01 and 11 capture it
    ap(1, 8'h00, 32'h0000_000F);
    for (i = 0; i < 4; i++) begin
      drv <= 4'h0;
      repeat (8) @(posedge pclk);
      ap(1, 8'h28, {26'h0, 2'b10, 2'b00, i[1:0]});
      ap(0, 8'h04, 0);
      c1 = rd[15:0];
      drv <= 4'h8;
      repeat (8) @(posedge pclk);
      ap(0, 8'h28, 0);
      chk(rd[5], i[0]);
      chk(pown[3], i != 0);
      chk(poe[3], 0);
      ap(0, 8'h2C, 0);
      if (i[0]) chk(rd[15:0] - c1 < 16'h0002, 1);
    end
    ap(1, 8'h00, 0);
    #1 chk(pown, 0);
    complete_run;
  end
endmodule // tb_timer_capture_compare_pwm
